// ### hdl/sar_ctrl_pkg.sv
// Shared constants and types for the sampling converter control block.
// Assumes a single 25 MHz core clock; all pin inputs are asynchronous.
package sar_ctrl_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 25;
  localparam int CONV_TIME_NS   = 1160;  // Longest conversion time
  localparam int CONV_CYCLES    = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int SYNC_STAGES    = 3;

  // ----------------------------------------------------------------
  // Data layout and fixed words
  // ----------------------------------------------------------------
  localparam int          RESULT_W     = 16;
  localparam int          BITCNT_W     = 5;
  localparam logic [15:0] ABORT_WORD   = 16'hff00;
  localparam logic [15:0] RESULT_RST   = 16'h0000;
  localparam logic [15:0] SIGN_FLIP    = 16'h8000;
  localparam logic [4:0]  BITCNT_LAST  = 5'h0f;
  localparam logic [10:0] CONV_CNT_MAX = 11'(CONV_CYCLES - 1);

  // ----------------------------------------------------------------
  // Conversion state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_SAMPLE  = 2'b00,
    ST_CONVERT = 2'b01,
    ST_WAIT    = 2'b10,
    ST_NAP     = 2'b11
  } conv_state_t;

  // Synchronised pin samples travelling together
  typedef struct packed {
    logic chip_select_n;
    logic conversion_start_n;
    logic frame_sync;
    logic serial_clock;
  } pin_bundle_t;

endpackage

// ### hdl/sar_conv_ctrl.sv
// Conversion and serial readout control of a 16-bit sampling converter.
// Assumes pins arrive asynchronously; select, start, frame sync and serial clock
// are filtered here; the analog result word arrives on the core clock as a plain input.
`timescale 1ns/1ps
`default_nettype none

module sar_conv_ctrl
  import sar_ctrl_pkg::*;
(
  input  wire logic                core_clk_i,          // 25 MHz core clock
  input  wire logic                rst_i,               // Async reset, active high
  input  wire logic                power_down_in_i,     // Power-down pin, high = down
  input  wire logic                conversion_start_n_i, // Conversion start pin
  input  wire logic                chip_select_n_i,     // Chip select pin, active low
  input  wire logic                frame_sync_i,        // Frame sync pin
  input  wire logic                serial_clock_i,      // Serial clock pin
  input  wire logic                output_format_select_i, // 0 binary, 1 two's compl.
  input  wire logic [RESULT_W-1:0] sample_code_i,       // Straight-binary analog code
  output logic                     busy_o,              // Conversion in progress
  output logic                     nap_o,               // Nap low-power state
  output logic                     powered_down_o,      // Full power-down active
  output logic                     serial_data_out_o,   // Serial data
  output logic                     serial_data_out_oe_o // Serial data drive enable
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Select, start, frame sync and serial clock each pass three flip-flops before any logic looks at them.
  // Stage three is compared with stage two, and the filtered copy
  // only moves when both agree, so a single-cycle glitch that slips
  // through the first stage never reaches the edge detectors.
  // Cost: about four core cycles of latency on each of these pins, which the
  // host must allow for when it paces its serial clock.
  // The serial clock is therefore limited to well below a quarter of
  // the core rate; faster clocks would lose edges in the filter.
  // Reset values match the idle level of each pin, avoiding a false
  // edge on the first cycle after reset.
  pin_bundle_t pins_raw;
  pin_bundle_t sync1_ff, sync2_ff, sync3_ff, stable_ff;
  pin_bundle_t nxt_sync1, nxt_sync2, nxt_sync3, nxt_stable;

  assign pins_raw = '{chip_select_n:      chip_select_n_i,
                      conversion_start_n: conversion_start_n_i,
                      frame_sync:         frame_sync_i,
                      serial_clock:       serial_clock_i};

  // A change counts once stages two and three agree, per bit
  always_comb begin
    nxt_sync1 = pins_raw;
    nxt_sync2 = sync1_ff;
    nxt_sync3 = sync2_ff;
    nxt_stable = stable_ff;
    for (int i = 0; i < 4; i++) begin
      if (sync2_ff[i] == sync3_ff[i]) begin
        nxt_stable[i] = sync3_ff[i];
      end
    end
  end

  // Idle levels: deselected, start high, frame sync high, clock low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff  <= 4'b1110;
      sync2_ff  <= 4'b1110;
      sync3_ff  <= 4'b1110;
      stable_ff <= 4'b1110;
    end else begin
      sync1_ff  <= nxt_sync1;
      sync2_ff  <= nxt_sync2;
      sync3_ff  <= nxt_sync3;
      stable_ff <= nxt_stable;
    end
  end

  // ----------------------------------------------------------------
  // Edge detection and qualified start
  // ----------------------------------------------------------------
  // Edges are found by comparing the filtered level with its copy
  // from the previous cycle; each detector is high for one cycle.
  // Frame sync and serial clock edges are masked by the filtered
  // select, so activity on a shared bus while deselected is ignored.
  // The qualified start is a held register rather than a real latch:
  // it follows the start pin while selected and keeps its last value
  // while deselected. Its falling edge is the only conversion
  // trigger, so a start pulse with select high does nothing.
  logic prev_cs_n_ff, prev_fs_ff, prev_sclk_ff, qual_start_ff, prev_qual_ff;
  logic nxt_qual_start;
  logic cs_n, cs_fall, fs_rise, fs_fall, sclk_rise, sclk_fall, qual_fall;

  assign cs_n      = stable_ff.chip_select_n;
  assign cs_fall   = prev_cs_n_ff & ~cs_n;
  // Frame sync and serial clock only count while selected
  assign fs_rise   = ~cs_n & stable_ff.frame_sync & ~prev_fs_ff;
  assign fs_fall   = ~cs_n & ~stable_ff.frame_sync & prev_fs_ff;
  assign sclk_rise = ~cs_n & stable_ff.serial_clock & ~prev_sclk_ff;
  assign sclk_fall = ~cs_n & ~stable_ff.serial_clock & prev_sclk_ff;
  assign qual_fall = prev_qual_ff & ~qual_start_ff;

  // Transparent latch on select low, built as a held register
  always_comb begin
    nxt_qual_start = qual_start_ff;
    if (!cs_n) begin
      nxt_qual_start = stable_ff.conversion_start_n;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      prev_cs_n_ff  <= 1'b1;
      prev_fs_ff    <= 1'b1;
      prev_sclk_ff  <= 1'b0;
      qual_start_ff <= 1'b1;
      prev_qual_ff  <= 1'b1;
    end else begin
      prev_cs_n_ff  <= cs_n;
      prev_fs_ff    <= stable_ff.frame_sync;
      prev_sclk_ff  <= stable_ff.serial_clock;
      qual_start_ff <= nxt_qual_start;
      prev_qual_ff  <= qual_start_ff;
    end
  end

  // ----------------------------------------------------------------
  // Conversion state machine
  // ----------------------------------------------------------------
  // Four states:
  //   Sample  - acquiring, waits for a qualified start fall
  //   Convert - counting a fixed number of core cycles
  //   Wait    - idle after a conversion or an abort
  //   Nap     - idle, entered when start was low at the end
  // A qualified start fall while converting aborts to wait and
  // leaves the fixed abort word as the stored result.
  // The analog code is taken on the last conversion cycle, so the
  // stored result changes on the same edge as busy falls.
  // Wait and nap leave only through sampling; a start fall seen
  // there is ignored, which keeps a stray edge from starting a
  // conversion without an acquisition phase.
  conv_state_t     state_ff, nxt_state;
  logic [10:0]     conv_cnt_ff, nxt_conv_cnt;
  logic [15:0]     result_ff, nxt_result;
  logic            done_pulse;
  logic            sample_cmd;

  assign sample_cmd = qual_start_ff & ~cs_n;
  assign done_pulse = (state_ff == ST_CONVERT) && !qual_fall && (conv_cnt_ff == CONV_CNT_MAX);

  always_comb begin
    nxt_state    = state_ff;
    nxt_conv_cnt = conv_cnt_ff;
    nxt_result   = result_ff;
    case (state_ff)
      ST_SAMPLE: begin
        if (qual_fall) begin
          nxt_state    = ST_CONVERT;
          nxt_conv_cnt = '0;
        end
      end
      ST_CONVERT: begin
        if (qual_fall) begin
          nxt_state  = ST_WAIT;
          nxt_result = ABORT_WORD;
        end else if (conv_cnt_ff == CONV_CNT_MAX) begin
          // Result swap coincides with busy falling
          nxt_result = output_format_select_i ? (sample_code_i ^ SIGN_FLIP)
                                              : sample_code_i;
          if (sample_cmd) begin
            nxt_state = ST_SAMPLE;
          end else if (!qual_start_ff) begin
            nxt_state = ST_NAP;
          end else begin
            nxt_state = ST_WAIT;
          end
        end else begin
          nxt_conv_cnt = conv_cnt_ff + 11'h001;
        end
      end
      ST_WAIT, ST_NAP: begin
        if (sample_cmd) begin
          nxt_state = ST_SAMPLE;
        end
      end
      default: nxt_state = ST_WAIT;
    endcase
  end

  // Power-down forces the same state as reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff    <= ST_WAIT;
      conv_cnt_ff <= 11'h000;
      result_ff   <= RESULT_RST;
    end else if (power_down_in_i) begin
      state_ff    <= ST_WAIT;
      conv_cnt_ff <= 11'h000;
      result_ff   <= RESULT_RST;
    end else begin
      state_ff    <= nxt_state;
      conv_cnt_ff <= nxt_conv_cnt;
      result_ff   <= nxt_result;
    end
  end

  assign busy_o         = (state_ff == ST_CONVERT);
  assign nap_o          = (state_ff == ST_NAP);
  assign powered_down_o = power_down_in_i;

  // ----------------------------------------------------------------
  // Serial readout, reloaded at conversion end while framed
  // ----------------------------------------------------------------
  // A frame starts on a filtered select fall or a frame sync rise,
  // which both copy the stored result into the shift register.
  // The first serial clock fall after that arms the shifter, and
  // each later rise moves one bit, most significant first.
  // After fifteen moves the counter stops and the last bit stays
  // on the output until the next frame begins.
  // A restart in mid-frame simply reloads, abandoning the old frame.
  // With frame sync high and select low at the end of a conversion,
  // the new result is loaded at once, so a waiting host sees the
  // fresh word without a second frame sync pulse.
  // Limitation: a frame started right at busy fall may carry either
  // word, so the host should keep clear of that edge.
  logic [15:0] shift_ff, nxt_shift;
  logic [4:0]  bit_cnt_ff, nxt_bit_cnt;
  logic        armed_ff, nxt_armed;
  logic        sdo_ff, nxt_sdo;

  // Shift register reads the stored word, so a mid-conversion read
  // returns the previous result
  always_comb begin
    nxt_shift   = shift_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_armed   = armed_ff;
    if (cs_fall || fs_rise) begin
      nxt_shift   = result_ff;
      nxt_bit_cnt = '0;
      nxt_armed   = 1'b0;
    end else if (done_pulse && stable_ff.frame_sync && !cs_n) begin
      nxt_shift   = nxt_result;
      nxt_bit_cnt = '0;
      nxt_armed   = 1'b0;
    end else begin
      if (sclk_fall) begin
        nxt_armed = 1'b1;
      end
      if (sclk_rise && armed_ff && bit_cnt_ff != BITCNT_LAST) begin
        nxt_shift   = {shift_ff[14:0], shift_ff[15]};
        nxt_bit_cnt = bit_cnt_ff + 5'h01;
      end
    end
    nxt_sdo = nxt_shift[15];        // LSB held after word ends
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_ff   <= RESULT_RST;
      bit_cnt_ff <= 5'h00;
      armed_ff   <= 1'b0;
      sdo_ff     <= 1'b0;
    end else if (power_down_in_i) begin
      shift_ff   <= RESULT_RST;
      bit_cnt_ff <= 5'h00;
      armed_ff   <= 1'b0;
      sdo_ff     <= 1'b0;
    end else begin
      shift_ff   <= nxt_shift;
      bit_cnt_ff <= nxt_bit_cnt;
      armed_ff   <= nxt_armed;
      sdo_ff     <= nxt_sdo;
    end
  end

  assign serial_data_out_o    = sdo_ff;
  // Released while deselected or powered down
  assign serial_data_out_oe_o = ~cs_n & ~power_down_in_i;

endmodule

`default_nettype wire

// ### test/sar_conv_monitor.sv
// Port checker for sar_conv_ctrl, bound to every instance.
// Assumes one core clock domain cleared by rst_i.
`timescale 1ns/1ps
`default_nettype none
module sar_conv_monitor (
  input wire logic core_clk_i,          // Core clock
  input wire logic rst_i,               // Async reset
  input wire logic power_down_in_i,     // Power-down pin
  input wire logic chip_select_n_i,     // Select pin
  input wire logic busy_o,              // Busy flag
  input wire logic nap_o,               // Nap flag
  input wire logic powered_down_o,      // Down flag
  input wire logic serial_data_out_oe_o // Data drive enable
);
  logic [5:0] busy_cnt_ff;
  logic [5:0] nxt_busy_cnt;
  // Busy run length; six bits so an overrun shows before wrap
  always_comb nxt_busy_cnt = busy_o ? busy_cnt_ff + 6'h01 : 6'h00;
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) busy_cnt_ff <= 6'h00;
    else busy_cnt_ff <= nxt_busy_cnt;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // Eight cycles of select high flush the pin filter
  busy_len_a: assert property (busy_o |-> busy_cnt_ff < 6'h1d)
    else $error("busy too long");
  busy_nap_a: assert property (!(busy_o && nap_o))
    else $error("busy in nap");
  pd_mirror_a: assert property (powered_down_o == power_down_in_i)
    else $error("down flag wrong");
  pd_idle_a: assert property (power_down_in_i |=> !busy_o && !nap_o)
    else $error("active while down");
  pd_oe_a: assert property (power_down_in_i |-> !serial_data_out_oe_o)
    else $error("drive while down");
  desel_oe_a: assert property (chip_select_n_i [*8] |-> !serial_data_out_oe_o)
    else $error("drive while deselected");
  desel_start_a: assert property (chip_select_n_i [*8] |-> !$rose(busy_o))
    else $error("start while deselected");
  conv_entry_a: assert property ($rose(busy_o) |-> !$past(nap_o))
    else $error("convert from nap");
  nap_entry_a: assert property ($rose(nap_o) |-> $past(busy_o))
    else $error("nap not after end");
  nap_exit_a: assert property (nap_o |=> !busy_o)
    else $error("nap skipped sampling");
endmodule
bind sar_conv_ctrl sar_conv_monitor u_sar_conv_monitor (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .power_down_in_i(power_down_in_i), .chip_select_n_i(chip_select_n_i), .busy_o(busy_o),
  .nap_o(nap_o), .powered_down_o(powered_down_o), .serial_data_out_oe_o(serial_data_out_oe_o));
`default_nettype wire

// ### test/sar_host_model.sv
// Host model: start, select, frame sync and serial clock pins.
// Assumes the core clock paces pin changes; sclk also runs while deselected.
`timescale 1ns/1ps
`default_nettype none
module sar_host_model (
  input  wire logic core_clk_i,           // Pacing clock
  input  wire logic serial_data_out_i,    // Device data
  output var  logic conversion_start_n_o, // Start pin
  output var  logic chip_select_n_o,      // Select pin
  output var  logic frame_sync_o,         // Frame sync pin
  output var  logic serial_clock_o        // Serial clock
);
  logic [15:0] rx = 16'h0000;
  // Idle pins; frame sync tied high for select-framed reads
  initial begin
    conversion_start_n_o = 1'b1;
    chip_select_n_o      = 1'b1;
    frame_sync_o         = 1'b1;
    serial_clock_o       = 1'b1;
  end
  // Change off the core edge, then hold to keep quiet zones clear
  task automatic pins(input logic st, cs, fs, input int w);
    @(negedge core_clk_i);
    conversion_start_n_o = st;
    chip_select_n_o      = cs;
    frame_sync_o         = fs;
    repeat (w) @(negedge core_clk_i);
  endtask
  // First fall arms; bits read late, since the filter delays them
  task automatic shift(input int n);
    rx = {rx[14:0], serial_data_out_i};
    serial_clock_o = 1'b0;
    #160;
    repeat (n - 1) begin
      serial_clock_o = 1'b1;
      #160;
      serial_clock_o = 1'b0;
      #120;
      rx = {rx[14:0], serial_data_out_i}; // Sampled off the core edge
      #40;
    end
    serial_clock_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### test/sar_conv_ctrl_tb_top.sv
// Bench for sar_conv_ctrl: conversions, abort, nap, both read modes.
// Assumes the host model drives the pins and the monitor is bound.
`timescale 1ns/1ps
`default_nettype none
module sar_conv_ctrl_tb_top;
  import sar_ctrl_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, pd = 1'b0, fmt = 1'b0;
  wire logic   st_n, cs_n, fs, sclk, busy, nap, pdn, serial_data_out, oe;
  logic [15:0] code = 16'h0000, prev;
  logic [15:0] corner [4] = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
  int          n_errors = 0, samples_checked = 0, cyc = 0, run = 0, k, t;
  sar_conv_ctrl u_sar_conv_ctrl (.core_clk_i(clk), .rst_i(rst), .power_down_in_i(pd),
    .conversion_start_n_i(st_n), .chip_select_n_i(cs_n), .frame_sync_i(fs), .serial_clock_i(sclk),
    .output_format_select_i(fmt), .sample_code_i(code), .busy_o(busy), .nap_o(nap),
    .powered_down_o(pdn), .serial_data_out_o(serial_data_out), .serial_data_out_oe_o(oe));
  sar_host_model u_sar_host_model (.core_clk_i(clk), .serial_data_out_i(serial_data_out),
    .conversion_start_n_o(st_n), .chip_select_n_o(cs_n), .frame_sync_o(fs), .serial_clock_o(sclk));
  // ----------------------------------------------------------------
  // Clock, busy length and hang guard
  // ----------------------------------------------------------------
  always #20 clk = ~clk;
  always @(posedge clk) begin
    run = run + int'(busy === 1'b1);
    if (++cyc == 20000) begin
      n_errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [15:0] got, exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] fmt_word(input logic [15:0] c, input logic f);
    return f ? c ^ 16'h8000 : c;
  endfunction
  // Seventeen samples: the word, then the held lsb
  function automatic logic [15:0] frame(input logic [15:0] w);
    return {w[14:0], w[0]};
  endfunction
  // Sample, start, set end levels; abort by a second start fall
  task automatic convert(input logic st_end, cs_end, ab);
    u_sar_host_model.pins(1'b1, 1'b0, fs, 8);
    check(16'(nap), 16'h0000);
    run = 0;
    u_sar_host_model.pins(1'b0, 1'b0, fs, 10);
    check(16'(busy), 16'h0001);
    u_sar_host_model.pins(st_end | ab, 1'b0, fs, 5);
    if (ab) u_sar_host_model.pins(1'b0, 1'b0, fs, 0);
    if (cs_end) u_sar_host_model.pins(st_end, 1'b1, fs, 0);
    for (k = 0; k < 40 && busy !== 1'b0; k++) @(negedge clk);
    check(ab ? 16'(run < 29) : 16'(run), ab ? 16'h0001 : 16'h001d);
    @(negedge clk);
    check(16'(nap), 16'(!(st_end | ab)));
  endtask
  task automatic read(input logic fsm, input int n, input logic [15:0] exp);
    if (fsm) begin
      u_sar_host_model.pins(st_n, 1'b0, 1'b0, 8);
      u_sar_host_model.pins(st_n, 1'b0, 1'b1, 8);
      u_sar_host_model.pins(st_n, 1'b0, 1'b0, 6);
    end else begin
      u_sar_host_model.pins(st_n, 1'b1, 1'b1, 4);
      u_sar_host_model.pins(st_n, 1'b0, 1'b1, 8);
    end
    u_sar_host_model.shift(n);
    if (n == 17) check(u_sar_host_model.rx, exp);
    if (!fsm) begin
      u_sar_host_model.pins(st_n, 1'b1, 1'b1, 8);
      u_sar_host_model.shift(3);
    end
    $display("frame done at %0t", $time);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Reads follow busy fall, except the frame held across a conversion and the read after power-down
  initial begin
    k = $urandom(32'h492d);
    repeat (20) @(negedge clk);
    rst = 1'b0;
    check(16'({busy, nap, oe}), 16'h0000);
    for (t = 0; t < 8; t++) begin
      code = t < 4 ? corner[t] : 16'($urandom);
      fmt  = t[2];
      convert(1'b1, t[1], 1'b0);
      prev = fmt_word(code, fmt);
      read(t[0], 6, 16'h0000);
      read(t[0], 17, frame(prev));
    end
    convert(1'b0, 1'b0, 1'b0);
    convert(1'b1, 1'b0, 1'b1);
    read(1'b0, 17, frame(16'hff00));
    u_sar_host_model.pins(st_n, 1'b0, 1'b0, 8);
    u_sar_host_model.pins(st_n, 1'b0, 1'b1, 8);
    code = fmt_word(16'h00ff, fmt);
    fork
      convert(1'b1, 1'b0, 1'b0);
      begin
        repeat (20) @(negedge clk);
        check(16'(serial_data_out), 16'h0001);
      end
    join
    check(16'(serial_data_out), 16'h0000);
    read(1'b1, 17, frame(16'h00ff));
    pd = 1'b1;
    repeat (4) @(negedge clk);
    check(16'({busy, nap, oe}), 16'h0000);
    pd = 1'b0;
    read(1'b0, 17, 16'h0000);
    give_verdict();
  end
endmodule
`default_nettype wire
